// ===== logic/sas_fifo.v
// Parameterised synchronous FIFO with valid and ready on both sides
module sas_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 16,
  parameter AW = 4
)
(
  input wire ref_clk,
  input wire reset,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr;
  reg [AW:0] rd_ptr;
  wire do_wr;
  wire do_rd;

  assign in_ready = (wr_ptr - rd_ptr) != DEPTH[AW:0];
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = mem[rd_ptr[AW-1:0]];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always @(posedge ref_clk)
  begin
    if (do_wr)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// ===== logic/sas_sequencer.v
// Conversion sequencer, result registers and register port for the SAR core
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`include "sas_defines.vh"

// Contract
// - One converter, 12-bit results, eight channels
// - Eight single-ended or four differential pairs; scan modes still issue channels 4-7 with conv_diff set
// - Single mode converts selected channel once
// - Scan converts enabled channels ascending once
// - Continuous scan repeats until software stops
// - Burst converts one channel into FIFO
// - Writing start bit one begins conversion
// - External trigger pin also starts conversion
// - Per-channel result with valid and overrun
// - Compare result, optional interrupt on match
// - Channel 7 from pin or bandgap
// - Self-calibration runs before normal conversions
module sas_sequencer
(
  input wire ref_clk,
  input wire reset,
  input wire [5:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire external_trigger_pin,
  output reg conv_req,
  output reg cal_req,
  output reg [2:0] conv_chan,
  output reg conv_diff,
  output reg ch7_bandgap,
  input wire conv_done,
  input wire [11:0] conv_result,
  output reg cmp_irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CAL = 2'h1;
  localparam ST_PICK = 2'h2;
  localparam ST_CONV = 2'h3;

  reg [1:0] state;
  reg [31:0] ctrl;
  reg [7:0] chen;
  reg [11:0] cmp_val;
  reg cmp_flag;
  reg cal_done;
  reg trig_d;
  reg [11:0] res_val [0:7];
  reg [7:0] res_valid;
  reg [7:0] res_ovr;
  reg [3:0] scan_pos;

  wire [1:0] mode;
  wire [2:0] sel_ch;
  wire trig_edge;
  wire start;
  wire stop;
  wire en_now;
  wire fifo_in_ready;
  wire [11:0] fifo_out_data;
  wire fifo_out_valid;
  wire fifo_pop;
  wire fifo_push;
  wire [7:0] rd_hit;
  reg [3:0] next_scan;
  reg found;
  integer k;

  assign mode = ctrl[`SAS_CTRL_MODE_HI:`SAS_CTRL_MODE_LO];
  // Differential mode only has four pairs, so the top select bit is dropped
  assign sel_ch = ctrl[`SAS_CTRL_DIFF] ?
                  {1'b0, ctrl[`SAS_CTRL_CH_LO+1:`SAS_CTRL_CH_LO]} :
                  ctrl[`SAS_CTRL_CH_HI:`SAS_CTRL_CH_LO];
  assign trig_edge = external_trigger_pin && !trig_d;
  assign start = (wr && addr == `SAS_REG_CTRL && wdata[`SAS_CTRL_START])
                 || (ctrl[`SAS_CTRL_TRGEN] && trig_edge);
  assign stop = wr && addr == `SAS_REG_CTRL && !wdata[`SAS_CTRL_EN];
  // A write that sets EN and START together must start at once
  assign en_now = (wr && addr == `SAS_REG_CTRL) ? wdata[`SAS_CTRL_EN]
                  : ctrl[`SAS_CTRL_EN];
  assign fifo_pop = rd && addr == `SAS_REG_FIFO;
  assign fifo_push = state == ST_CONV && conv_done
                     && mode == `SAS_MODE_BURST;

  sas_fifo #(
    .WIDTH(12),
    .DEPTH(`SAS_FIFO_DEPTH),
    .AW(`SAS_FIFO_AW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_data(conv_result),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );

  // Lowest enabled channel at or above the current scan position
  always @*
  begin
    next_scan = 4'h8;
    found = 1'b0;
    for (k = 0; k < 8; k = k + 1)
    begin
      if (!found && chen[k] && k >= scan_pos)
      begin
        next_scan = k[3:0];
        found = 1'b1;
      end
    end
  end

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      ctrl <= `SAS_CTRL_RESET;
      chen <= 8'h00;
      cmp_val <= 12'h000;
      cmp_flag <= 1'b0;
      cal_done <= 1'b0;
      trig_d <= 1'b0;
      scan_pos <= 4'h0;
      conv_req <= 1'b0;
      cal_req <= 1'b0;
      conv_chan <= 3'h0;
      conv_diff <= 1'b0;
      ch7_bandgap <= 1'b0;
      cmp_irq <= 1'b0;
    end
    else
    begin
      trig_d <= external_trigger_pin;
      conv_req <= 1'b0;
      cal_req <= 1'b0;
      conv_diff <= ctrl[`SAS_CTRL_DIFF];
      ch7_bandgap <= ctrl[`SAS_CTRL_CH7BG];
      cmp_irq <= cmp_flag && ctrl[`SAS_CTRL_CMPIE];
      if (wr && addr == `SAS_REG_CTRL)
        ctrl <= {wdata[31:8], 1'b0, wdata[6:0]};
      if (wr && addr == `SAS_REG_CHEN)
        chen <= wdata[7:0];
      if (wr && addr == `SAS_REG_CMP)
        cmp_val <= wdata[11:0];
      if (wr && addr == `SAS_REG_STATUS && wdata[0])
        cmp_flag <= 1'b0;
      if (wr && addr == `SAS_REG_CTRL && wdata[`SAS_CTRL_CAL])
        cal_done <= 1'b0;
      if (state == ST_CONV && conv_done && conv_result == cmp_val)
        cmp_flag <= 1'b1;
      case (state)
        ST_IDLE:
        begin
          if (wr && addr == `SAS_REG_CTRL && wdata[`SAS_CTRL_CAL])
          begin
            cal_req <= 1'b1;
            state <= ST_CAL;
          end
          else if (start && en_now && cal_done)
          begin
            scan_pos <= 4'h0;
            state <= ST_PICK;
          end
        end
        ST_CAL:
        begin
          if (conv_done)
          begin
            cal_done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_PICK:
        begin
          // The stop strobe may land mid-conversion, so the level is used too
          if (stop || !ctrl[`SAS_CTRL_EN])
            state <= ST_IDLE;
          else if (mode == `SAS_MODE_SINGLE || mode == `SAS_MODE_BURST)
          begin
            if (fifo_in_ready || mode == `SAS_MODE_SINGLE)
            begin
              conv_chan <= sel_ch;
              conv_req <= 1'b1;
              state <= ST_CONV;
            end
          end
          else if (next_scan[3])
          begin
            scan_pos <= 4'h0;
            if (mode == `SAS_MODE_SCAN)
              state <= ST_IDLE;
          end
          else
          begin
            conv_chan <= next_scan[2:0];
            scan_pos <= next_scan + 4'h1;
            conv_req <= 1'b1;
            state <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          if (conv_done)
          begin
            if (mode == `SAS_MODE_SINGLE || stop || !ctrl[`SAS_CTRL_EN])
              state <= ST_IDLE;
            else
              state <= ST_PICK;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : gen_res
      wire hit_wr;
      assign hit_wr = state == ST_CONV && conv_done && conv_chan == g
                      && mode != `SAS_MODE_BURST;
      assign rd_hit[g] = rd && addr == (`SAS_REG_RESULT0 + g * 4);
      always @(posedge ref_clk or posedge reset)
      begin
        if (reset)
        begin
          res_val[g] <= 12'h000;
          res_valid[g] <= 1'b0;
          res_ovr[g] <= 1'b0;
        end
        else if (hit_wr)
        begin
          res_val[g] <= conv_result;
          res_valid[g] <= 1'b1;
          res_ovr[g] <= res_valid[g] && !rd_hit[g];
        end
        else if (rd_hit[g])
        begin
          res_valid[g] <= 1'b0;
          res_ovr[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      rdata <= 32'h0000_0000;
    else if (rd)
    begin
      rdata <= 32'h0000_0000;
      if (addr[5] == 1'b0 && addr[1:0] == 2'h0)
        rdata <= {14'h0000, res_ovr[addr[4:2]], res_valid[addr[4:2]],
                  4'h0, res_val[addr[4:2]]};
      else if (addr == `SAS_REG_CTRL)
        rdata <= ctrl;
      else if (addr == `SAS_REG_CHEN)
        rdata <= {24'h000000, chen};
      else if (addr == `SAS_REG_CMP)
        rdata <= {20'h00000, cmp_val};
      else if (addr == `SAS_REG_STATUS)
        rdata <= {24'h000000, fifo_in_ready, fifo_out_valid, cal_done,
                  (state != ST_IDLE), 3'h0, cmp_flag};
      else if (addr == `SAS_REG_FIFO)
        rdata <= {15'h0000, fifo_out_valid, 4'h0, fifo_out_data};
    end
  end
endmodule

// ===== pkg/sas_defines.vh
// Register offsets, field positions and FIFO sizing for the converter sequencer
`ifndef SAS_DEFINES_VH
`define SAS_DEFINES_VH

`define SAS_ADDR_W 6
`define SAS_REG_RESULT0 6'h00
`define SAS_REG_CTRL 6'h20
`define SAS_REG_CHEN 6'h24
`define SAS_REG_CMP 6'h28
`define SAS_REG_STATUS 6'h2c
`define SAS_REG_FIFO 6'h30

`define SAS_CTRL_EN 0
`define SAS_CTRL_MODE_LO 1
`define SAS_CTRL_MODE_HI 2
`define SAS_CTRL_TRGEN 3
`define SAS_CTRL_DIFF 4
`define SAS_CTRL_CH7BG 5
`define SAS_CTRL_CMPIE 6
`define SAS_CTRL_START 7
`define SAS_CTRL_CAL 8
`define SAS_CTRL_CH_LO 12
`define SAS_CTRL_CH_HI 14
`define SAS_CTRL_RESET 32'h0000_0000

`define SAS_MODE_SINGLE 2'h0
`define SAS_MODE_BURST 2'h1
`define SAS_MODE_SCAN 2'h2
`define SAS_MODE_CONT 2'h3

`define SAS_RES_VALID 16
`define SAS_RES_OVR 17

`define SAS_FIFO_DEPTH 16
`define SAS_FIFO_AW 4

`endif

// ===== verif/sar_adc_sequencer_tb.sv
// Self-checking bench for the converter sequencer
`include "sas_defines.vh"
module sar_adc_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] CT = `SAS_REG_CTRL, ST = `SAS_REG_STATUS;
  logic ref_clk = 0, reset = 1, wr = 0, rd = 0, trg = 0;
  logic conv_req, cal_req, conv_diff, bg, conv_done, cmp_irq;
  logic [5:0] addr = 0;
  logic [31:0] wdata = 0, rdata, s;
  logic [3:0] lat = 1;
  logic [2:0] conv_chan, q[$];
  logic [11:0] conv_result;
  int err_count = 0, check_count = 0, n;
  logic [31:0] rows[3][3] = '{'{32'h81, 32'h0, 32'h1_0000},
    '{32'h3081, 32'hc, 32'h1_0601}, '{32'h70a1, 32'h1c, 32'h1_0fff}};
  sas_sequencer i_dut (.ref_clk, .reset, .addr, .wdata, .wr, .rd,
    .rdata, .external_trigger_pin(trg), .conv_req, .cal_req, .conv_chan,
    .conv_diff, .ch7_bandgap(bg), .conv_done, .conv_result, .cmp_irq);
  sas_core_model i_core (.ref_clk, .reset, .conv_req, .cal_req,
    .ch7_bandgap(bg), .conv_chan, .lat, .conv_done, .conv_result);
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
    if (conv_req)
      q.push_back(conv_chan);
  task automatic chk(input string m, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", m, e, g);
    end
  endtask
  task automatic wr32(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge ref_clk);
    wr <= 0;
  endtask
  task automatic rd32(input logic [5:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    {addr, rd} <= {a, 1'b1};
    @(posedge ref_clk);
    rd <= 0;
    #1;
    d = rdata;
  endtask
  task automatic rchk(input string m, input logic [5:0] a,
      input logic [31:0] k, e);
    logic [31:0] t;
    rd32(a, t);
    chk(m, e, t & k);
  endtask
  // Polls busy; a hung sequencer ends as a mismatch, not a stall
  task automatic idle;
    logic [31:0] t;
    t = 32'h10;
    for (int i = 0; i < 300 && t[4]; i++) rd32(ST, t);
    chk("busy", 0, t[4]);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    err_count++;
    close_out;
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    reset <= 0;
    chk("outs", 0, {conv_req, cal_req, conv_chan, bg, cmp_irq});
    wr32(CT, 32'h101);
    idle;
    foreach (rows[i])
    begin
      wr32(CT, rows[i][0]);
      idle;
      rchk("res", rows[i][1][5:0], 32'h3_0fff, rows[i][2]);
      rchk("clr", rows[i][1][5:0], 32'h3_0000, 0);
      $display("row %0d end", i);
    end
    repeat (2)
    begin
      wr32(CT, 32'h5081);
      idle;
    end
    rchk("ovr", 6'h14, 32'h3_0000, 32'h3_0000);
    n = q.size();
    wr32(`SAS_REG_CHEN, 32'h25);
    wr32(CT, 32'h85);
    idle;
    chk("scan", 32'h215, {q.size() == n + 3, q[n], q[n+1], q[n+2]});
    $display("scan end");
    n = q.size();
    lat <= 9;
    wr32(`SAS_REG_CHEN, 32'h03);
    wr32(CT, 32'h87);
    for (int i = 0; i < 500 && q.size() < n + 5; i++) @(posedge ref_clk);
    wr32(CT, 0);
    idle;
    chk("cont", 32'o1010, {q[n], q[n+1], q[n+2], q[n+3], q[n+4]});
    $display("cont end");
    n = q.size();
    wr32(CT, 32'h6083);
    s = 32'h80;
    for (int i = 0; i < 300 && s[7]; i++) rd32(ST, s);
    wr32(CT, 0);
    idle;
    rchk("full", ST, 32'hc0, 32'h40);
    for (int i = 0; i < 16; i++)
      rchk("fifo", 6'h30, 32'h1_0fff, {16'h1, 4'h0, 3'h6, 9'(n + i)});
    rchk("empty", ST, 32'h40, 0);
    $display("burst end");
    wr32(CT, 32'h6019);
    n = q.size();
    @(posedge ref_clk);
    trg <= 1;
    repeat (3) @(posedge ref_clk);
    trg <= 0;
    idle;
    chk("trig", n + 1, q.size());
    chk("pair", 2, q[n]);
    $display("trig end");
    n = q.size();
    wr32(`SAS_REG_CMP, {20'h0, 3'h1, 9'(n)});
    wr32(ST, 32'h1);
    wr32(CT, 32'h10c1);
    idle;
    chk("irq", 1, cmp_irq);
    wr32(ST, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("irq off", 0, cmp_irq);
    rchk("unmapped", 6'h3c, 32'hffff_ffff, 0);
    $display("compare end");
    close_out;
  end
endmodule

// ===== verif/sas_core_model.sv
// Behavioural analog core with a settable answer delay
module sas_core_model (
  input wire ref_clk, reset, conv_req, cal_req, ch7_bandgap,
  input wire [2:0] conv_chan,
  input wire [3:0] lat,
  output logic conv_done,
  output logic [11:0] conv_result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic busy;
  logic [3:0] cnt;
  logic [8:0] seq;
  logic [11:0] res;
  // Outside the done pulse the result lines carry junk
  assign conv_result = conv_done ? res : ~res;
  always @(posedge ref_clk or posedge reset)
    if (reset)
      {busy, cnt, seq, res, conv_done} <= '0;
    else
    begin
      conv_done <= busy && cnt == 0;
      cnt <= cnt - 4'h1;
      if (cnt == 0)
        busy <= 0;
      if (conv_req || cal_req)
      begin
        {busy, cnt} <= {1'b1, lat};
        seq <= seq + conv_req;
        res <= {conv_chan, seq};
        if (ch7_bandgap && conv_chan == 3'h7)
          res <= 12'hfff;
      end
    end
endmodule

// ===== verif/sas_seq_sva.sv
// Checker on the register port and core handshake
`include "sas_defines.vh"
module sas_seq_chk (
  input logic ref_clk, reset, wr, rd, conv_req, cal_req,
  input logic conv_diff, ch7_bandgap, conv_done, cmp_irq,
  input logic [5:0] addr,
  input logic [31:0] wdata, rdata,
  input logic [2:0] conv_chan
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic pend;
  wire cw = wr && addr == `SAS_REG_CTRL;
  always_ff @(posedge ref_clk or posedge reset)
    if (reset) pend <= 0;
    else if (conv_req || cal_req) pend <= 1;
    else if (conv_done) pend <= 0;
  property p_req; conv_req |=> !conv_req; endproperty
  a_req: assert property (p_req) else $error("req long");
  property p_cal; cal_req |=> !cal_req; endproperty
  a_cal: assert property (p_cal) else $error("cal long");
  property p_one; conv_req || cal_req |-> !pend; endproperty
  a_one: assert property (p_one) else $error("two jobs");
  property p_chan; pend |-> $stable(conv_chan); endproperty
  a_chan: assert property (p_chan) else $error("chan moved");
  property p_rdata; !rd |=> $stable(rdata); endproperty
  a_rdata: assert property (p_rdata) else $error("rdata moved");
  property p_bg; cw |-> ##2 ch7_bandgap == $past(wdata[5], 2); endproperty
  a_bg: assert property (p_bg) else $error("bandgap sel");
  property p_diff; cw |-> ##2 conv_diff == $past(wdata[4], 2); endproperty
  a_diff: assert property (p_diff) else $error("diff sel");
  property p_irq; cw && !wdata[6] |=> ##1 !cmp_irq; endproperty
  a_irq: assert property (p_irq) else $error("irq masked");
endmodule
bind sas_sequencer sas_seq_chk i_chk (.ref_clk, .reset, .wr, .rd,
  .conv_req, .cal_req, .conv_diff, .ch7_bandgap, .conv_done, .cmp_irq,
  .addr, .wdata, .rdata, .conv_chan);
